//--- nsc_pkg.sv
/*
  Shared constants of the negate, stack, call and return execution slice:
  instruction patterns, flag positions, reset values and sizes.
  Assumes a 16-bit instruction word and a 21-bit byte program counter.
*/
package nsc_pkg;
  // Sizes
  localparam int PC_W = 21;
  localparam int ADDR_W = 12;
  localparam int STK_DEPTH = 31;
  localparam int STK_PTR_W = 5;
  // Instruction patterns
  localparam logic [6:0] NEG_OPC = 7'h36;      // 0110 110a
  localparam logic [4:0] RELATIVE_CALL_OP_OPC = 5'h1b;    // 1101 1nnn
  localparam logic [7:0] LITERAL_RETURN_OP_OPC = 8'h0c;    // 0000 1100
  localparam logic [14:0] INTERRUPT_RETURN_OP_OPC = 15'h0008; // 0000 0000 0001 000s
  localparam logic [14:0] RETURN_OPC = 15'h0009; // 0000 0000 0001 001s
  localparam logic [15:0] POP_CODE = 16'h0006;
  localparam logic [15:0] PUSH_CODE = 16'h0005;
  localparam logic [15:0] RESET_CODE = 16'h00ff;
  localparam logic [15:0] NOP_CODE = 16'h0000;
  localparam logic [3:0] NOP_HI = 4'hf;
  // Addressing
  localparam logic [7:0] IDX_LIMIT = 8'h5f;    // Indexed when f <= 95
  localparam logic [7:0] ACC_SPLIT = 8'h60;    // Access bank low/high split
  localparam logic [3:0] ACC_HI_BANK = 4'hf;
  // Flag positions in the flags register
  localparam int FL_C = 0;
  localparam int FL_DC = 1;
  localparam int FL_Z = 2;
  localparam int FL_OV = 3;
  localparam int FL_N = 4;
  // Reset values
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [7:0] BSR_RST = 8'h00;
  // Four quarter-cycles per instruction cycle
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;
  // Execution states
  typedef enum logic [0:0] {
    NSC_RUN = 1'b0,
    NSC_FLUSH = 1'b1
  } nsc_state_t;
endpackage

//--- nsc_stk_if.sv
/*
  Carrier between the execution slice and its return stack memory.
  Assumes both sides share one clock.
*/
interface nsc_stk_if;
  logic wr_en;                               // Write strobe
  logic [nsc_pkg::STK_PTR_W-1:0] wr_addr;    // Write entry
  logic [nsc_pkg::PC_W-1:0] wr_data;         // Return address to store
  logic [nsc_pkg::STK_PTR_W-1:0] rd_addr;    // Entry to read
  logic [nsc_pkg::PC_W-1:0] rd_data;         // Registered read data
  modport core (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

//--- nsc_stack_mem.sv
/*
  Return stack storage: one write port, one registered read port.
  Assumes the core keeps addresses below DEPTH.
*/
module nsc_stack_mem #(
  parameter int DEPTH = nsc_pkg::STK_DEPTH
) (
  input wire logic clk,
  nsc_stk_if.mem stk
);
  // Storage entries
  logic [nsc_pkg::PC_W-1:0] mem_r [DEPTH];
  // Read data comes from a register
  logic [nsc_pkg::PC_W-1:0] rd_r;
  logic [nsc_pkg::PC_W-1:0] rd_nxt;

  // Pick the addressed entry
  always_comb
  begin
    rd_nxt = mem_r[stk.rd_addr];
  end

  // Store writes and register the read
  always_ff @(posedge clk)
  begin
    if (stk.wr_en)
    begin
      mem_r[stk.wr_addr] <= stk.wr_data;
    end
    rd_r <= rd_nxt;
  end

  assign stk.rd_data = rd_r;
endmodule

//--- nsc_exec.sv
/*
  Execution slice for negate-file, no-op and return stack instructions,
  run over four quarter-cycles per instruction cycle.
  Assumes the fetch stage offers a word at Q1 and follows pc_r, and that
  data memory answers a read in the same clock in which mem_rd_r is high.
*/
module nsc_exec #(
  parameter int STK_DEPTH = nsc_pkg::STK_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic ext_set_en,
  input wire logic [nsc_pkg::ADDR_W-1:0] fsr2_base,
  input wire logic irq_prio_en,
  input wire logic isr_low_level,
  input wire logic shadow_load,
  input wire logic [7:0] mem_rd_data,
  output logic [1:0] q_phase_r,
  output logic [nsc_pkg::PC_W-1:0] pc_r,
  output logic [7:0] w_r,
  output logic [4:0] flags_r,
  output logic [7:0] bank_select_register_r,
  output logic global_irq_enable_high_r,
  output logic peripheral_irq_enable_low_r,
  output logic [nsc_pkg::ADDR_W-1:0] mem_addr_r,
  output logic mem_rd_r,
  output logic mem_wr_r,
  output logic [7:0] mem_wdata_r,
  output logic flush_r,
  output logic soft_reset_r
);
  // Refuse a stack that the pointer cannot count
  if (STK_DEPTH < 2 || STK_DEPTH >= (1 << nsc_pkg::STK_PTR_W))
  begin : g_chk
    $error("nsc_exec: STK_DEPTH out of range");
  end

  nsc_stk_if stk ();

  nsc_stack_mem #(.DEPTH(STK_DEPTH)) u_stk (
    .clk(clk),
    .stk(stk)
  );

  // Registers without an output port
  nsc_pkg::nsc_state_t state_r, state_nxt;
  logic [15:0] ir_r, ir_nxt;                 // Instruction in execution
  logic ir_vld_r, ir_vld_nxt;                // Word is a real fetch
  logic [nsc_pkg::STK_PTR_W-1:0] ptr_r, ptr_nxt; // Entries in use
  logic [7:0] accumulator_shadow_r, ws_nxt;
  logic [4:0] flags_shadow_r, fs_nxt;
  logic [7:0] bank_select_shadow_r, bs_nxt;
  // Next values of output registers
  logic [1:0] q_nxt;
  logic [nsc_pkg::PC_W-1:0] pc_nxt;
  logic [7:0] w_nxt, bsr_nxt, wdata_nxt;
  logic [4:0] flags_nxt;
  logic gieh_nxt, giel_nxt, rd_nxt, wr_nxt, flush_nxt, srst_nxt;
  logic [nsc_pkg::ADDR_W-1:0] addr_nxt;
  // Decode of the word in execution
  logic is_neg, is_nop, is_pop, is_push, is_reset;
  logic is_rfie, is_ret, is_literal_return_op, is_relative_call_op;
  logic [7:0] fa, neg_val;
  logic [nsc_pkg::PC_W-1:0] pc_inc, rel_off;

  // Instruction decode and derived values
  always_comb
  begin
    is_neg = ir_r[15:9] == nsc_pkg::NEG_OPC;
    is_nop = ir_r == nsc_pkg::NOP_CODE || ir_r[15:12] == nsc_pkg::NOP_HI;
    is_pop = ir_r == nsc_pkg::POP_CODE;
    is_push = ir_r == nsc_pkg::PUSH_CODE;
    is_reset = ir_r == nsc_pkg::RESET_CODE;
    is_rfie = ir_r[15:1] == nsc_pkg::INTERRUPT_RETURN_OP_OPC;
    is_ret = ir_r[15:1] == nsc_pkg::RETURN_OPC;
    is_literal_return_op = ir_r[15:8] == nsc_pkg::LITERAL_RETURN_OP_OPC;
    is_relative_call_op = ir_r[15:11] == nsc_pkg::RELATIVE_CALL_OP_OPC;
    fa = ir_r[7:0];
    neg_val = 8'h00 - mem_rd_data;
    pc_inc = pc_r + 21'h000002;
    rel_off = {{9{ir_r[10]}}, ir_r[10:0], 1'b0};        // 2n, sign kept
  end

  // Stack port: read the top entry, write at the free entry
  always_comb
  begin
    stk.rd_addr = ptr_r - 5'h01;
    stk.wr_addr = ptr_r;
    stk.wr_data = pc_inc;
    stk.wr_en = q_phase_r == nsc_pkg::Q2 && ir_vld_r &&
      (is_push || is_relative_call_op) &&
      ptr_r < nsc_pkg::STK_PTR_W'(STK_DEPTH);
  end

  // Next state of the whole execution slice
  always_comb
  begin
    q_nxt = q_phase_r + 2'h1;
    state_nxt = state_r;
    ir_nxt = ir_r;
    ir_vld_nxt = ir_vld_r;
    ptr_nxt = ptr_r;
    ws_nxt = accumulator_shadow_r;
    fs_nxt = flags_shadow_r;
    bs_nxt = bank_select_shadow_r;
    pc_nxt = pc_r;
    w_nxt = w_r;
    flags_nxt = flags_r;
    bsr_nxt = bank_select_register_r;
    gieh_nxt = global_irq_enable_high_r;
    giel_nxt = peripheral_irq_enable_low_r;
    addr_nxt = mem_addr_r;
    rd_nxt = 1'b0;
    wr_nxt = 1'b0;
    wdata_nxt = mem_wdata_r;
    flush_nxt = 1'b0;
    srst_nxt = 1'b0;
    // Shadow copies taken on interrupt entry
    if (shadow_load)
    begin
      ws_nxt = w_r;
      fs_nxt = flags_r;
      bs_nxt = bank_select_register_r;
    end
    case (q_phase_r)
      nsc_pkg::Q1:
      begin
        // Take the fetched word, or a dead cycle after a transfer
        if (state_r == nsc_pkg::NSC_FLUSH)
        begin
          ir_nxt = nsc_pkg::NOP_CODE;
          ir_vld_nxt = 1'b0;
          flush_nxt = 1'b1;
          state_nxt = nsc_pkg::NSC_RUN;
        end
        else
        begin
          ir_nxt = instr_valid ? instr : nsc_pkg::NOP_CODE;
          ir_vld_nxt = instr_valid;
        end
      end
      nsc_pkg::Q2:
      begin
        if (ir_vld_r && is_neg)
        begin
          // Effective address of the file operand
          rd_nxt = 1'b1;
          if (ir_r[8])
            addr_nxt = {bank_select_register_r[3:0], fa};
          else if (ext_set_en && fa <= nsc_pkg::IDX_LIMIT)
            addr_nxt = fsr2_base + {4'h0, fa};
          else if (fa < nsc_pkg::ACC_SPLIT)
            addr_nxt = {4'h0, fa};
          else
            addr_nxt = {nsc_pkg::ACC_HI_BANK, fa};
        end
        else if (ir_vld_r && (is_push || is_relative_call_op))
        begin
          // Save pc+2; the write strobe rides on stk.wr_en
          if (stk.wr_en)
            ptr_nxt = ptr_r + 5'h01;
        end
        else if (ir_vld_r && is_reset)
        begin
          // Restart at PC_RST with pc, w, flags, bank, enables, shadows and pointer at reset values
          srst_nxt = 1'b1;
          state_nxt = nsc_pkg::NSC_RUN;
          ir_vld_nxt = 1'b0;
          ptr_nxt = '0;
          pc_nxt = nsc_pkg::PC_RST;
          w_nxt = nsc_pkg::W_RST;
          flags_nxt = nsc_pkg::FLAGS_RST;
          bsr_nxt = nsc_pkg::BSR_RST;
          gieh_nxt = 1'b0;
          giel_nxt = 1'b0;
          ws_nxt = nsc_pkg::W_RST;
          fs_nxt = nsc_pkg::FLAGS_RST;
          bs_nxt = nsc_pkg::BSR_RST;
        end
      end
      nsc_pkg::Q3:
      begin
        if (ir_vld_r && is_neg)
        begin
          // Write the negated byte back and update flags
          wr_nxt = 1'b1;
          wdata_nxt = neg_val;
          flags_nxt[nsc_pkg::FL_N] = neg_val[7];
          flags_nxt[nsc_pkg::FL_Z] = neg_val == 8'h00;
          flags_nxt[nsc_pkg::FL_C] = mem_rd_data == 8'h00;
          flags_nxt[nsc_pkg::FL_DC] = mem_rd_data[3:0] == 4'h0;
          flags_nxt[nsc_pkg::FL_OV] = mem_rd_data == 8'h80;
        end
      end
      nsc_pkg::Q4:
      begin
        if (!ir_vld_r || is_nop)
        begin
          // No-op or dead cycle: only a real word advances pc
          if (ir_vld_r)
            pc_nxt = pc_inc;
        end
        else if (is_relative_call_op)
        begin
          pc_nxt = pc_inc + rel_off;
          state_nxt = nsc_pkg::NSC_FLUSH;
        end
        else if (is_pop)
        begin
          if (ptr_r != '0)
            ptr_nxt = ptr_r - 5'h01;
          pc_nxt = pc_inc;
        end
        else if (is_rfie || is_ret || is_literal_return_op)
        begin
          // Pop the return address into pc
          pc_nxt = stk.rd_data;
          if (ptr_r != '0)
            ptr_nxt = ptr_r - 5'h01;
          state_nxt = nsc_pkg::NSC_FLUSH;
          if (is_literal_return_op)
            w_nxt = fa;
          if ((is_rfie || is_ret) && ir_r[0])
          begin
            w_nxt = accumulator_shadow_r;
            flags_nxt = flags_shadow_r;
            bsr_nxt = bank_select_shadow_r;
          end
          if (is_rfie)
          begin
            if (irq_prio_en && isr_low_level)
              giel_nxt = 1'b1;
            else
              gieh_nxt = 1'b1;
          end
        end
        else
        begin
          pc_nxt = pc_inc;
        end
      end
      default:
      begin
        q_nxt = nsc_pkg::Q1;
      end
    endcase
  end

  // Register every piece of state
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      q_phase_r <= nsc_pkg::Q1;
      state_r <= nsc_pkg::NSC_RUN;
      ir_r <= nsc_pkg::NOP_CODE;
      ir_vld_r <= 1'b0;
      ptr_r <= '0;
      accumulator_shadow_r <= nsc_pkg::W_RST;
      flags_shadow_r <= nsc_pkg::FLAGS_RST;
      bank_select_shadow_r <= nsc_pkg::BSR_RST;
      pc_r <= nsc_pkg::PC_RST;
      w_r <= nsc_pkg::W_RST;
      flags_r <= nsc_pkg::FLAGS_RST;
      bank_select_register_r <= nsc_pkg::BSR_RST;
      global_irq_enable_high_r <= 1'b0;
      peripheral_irq_enable_low_r <= 1'b0;
      mem_addr_r <= '0;
      mem_rd_r <= 1'b0;
      mem_wr_r <= 1'b0;
      mem_wdata_r <= 8'h00;
      flush_r <= 1'b0;
      soft_reset_r <= 1'b0;
    end
    else
    begin
      q_phase_r <= q_nxt;
      state_r <= state_nxt;
      ir_r <= ir_nxt;
      ir_vld_r <= ir_vld_nxt;
      ptr_r <= ptr_nxt;
      accumulator_shadow_r <= ws_nxt;
      flags_shadow_r <= fs_nxt;
      bank_select_shadow_r <= bs_nxt;
      pc_r <= pc_nxt;
      w_r <= w_nxt;
      flags_r <= flags_nxt;
      bank_select_register_r <= bsr_nxt;
      global_irq_enable_high_r <= gieh_nxt;
      peripheral_irq_enable_low_r <= giel_nxt;
      mem_addr_r <= addr_nxt;
      mem_rd_r <= rd_nxt;
      mem_wr_r <= wr_nxt;
      mem_wdata_r <= wdata_nxt;
      flush_r <= flush_nxt;
      soft_reset_r <= srst_nxt;
    end
  end

  // Checks on the behaviour above
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Transfer ends, then one dead cycle, then running again
  sequence xfer_end_s;
    q_phase_r == nsc_pkg::Q4 && ir_vld_r &&
      (is_relative_call_op || is_ret || is_rfie || is_literal_return_op);
  endsequence
  sequence dead_cycle_s;
    state_r == nsc_pkg::NSC_FLUSH ##1 flush_r && !ir_vld_r ##3 !ir_vld_r;
  endsequence

  neg_result_a: assert property (
    q_phase_r == nsc_pkg::Q3 && ir_vld_r && is_neg |=>
      mem_wr_r && mem_wdata_r == 8'h00 - $past(mem_rd_data))
    else $error("negate result wrong");
  neg_flags_a: assert property (
    q_phase_r == nsc_pkg::Q3 && ir_vld_r && is_neg |=>
      flags_r[nsc_pkg::FL_Z] == (mem_wdata_r == 8'h00) &&
      flags_r[nsc_pkg::FL_N] == mem_wdata_r[7] &&
      flags_r[nsc_pkg::FL_C] == ($past(mem_rd_data) == 8'h00))
    else $error("negate flags wrong");
  bank_addr_a: assert property (
    q_phase_r == nsc_pkg::Q2 && ir_vld_r && is_neg && ir_r[8] |=>
      mem_rd_r && mem_addr_r == {$past(bank_select_register_r[3:0]),
      $past(ir_r[7:0])})
    else $error("banked address wrong");
  indexed_addr_a: assert property (
    q_phase_r == nsc_pkg::Q2 && ir_vld_r && is_neg && !ir_r[8] &&
      ext_set_en && ir_r[7:0] <= nsc_pkg::IDX_LIMIT |=>
      mem_addr_r == $past(fsr2_base) + {4'h0, $past(ir_r[7:0])})
    else $error("indexed address wrong");
  pop_level_a: assert property (
    q_phase_r == nsc_pkg::Q4 && ir_vld_r && is_pop && ptr_r != '0 |=>
      ptr_r == $past(ptr_r) - 5'h01 && state_r == nsc_pkg::NSC_RUN)
    else $error("discard did not pop");
  push_level_a: assert property (
    q_phase_r == nsc_pkg::Q2 && ir_vld_r && is_push &&
      ptr_r < 5'd30 |=> ptr_r == $past(ptr_r) + 5'h01)
    else $error("save did not push");
  relative_call_op_target_a: assert property (
    q_phase_r == nsc_pkg::Q4 && ir_vld_r && is_relative_call_op |=>
      pc_r == $past(pc_r) + 21'h000002 + $past(rel_off))
    else $error("relative call target wrong");
  soft_reset_a: assert property (
    q_phase_r == nsc_pkg::Q2 && ir_vld_r && is_reset |=>
      soft_reset_r && pc_r == nsc_pkg::PC_RST && w_r == nsc_pkg::W_RST &&
      ptr_r == '0)
    else $error("software reset incomplete");
  literal_return_op_load_a: assert property (
    q_phase_r == nsc_pkg::Q4 && ir_vld_r && is_literal_return_op |=>
      w_r == $past(ir_r[7:0]) && pc_r == $past(stk.rd_data))
    else $error("literal return wrong");
  shadow_keep_a: assert property (
    q_phase_r == nsc_pkg::Q4 && ir_vld_r && is_ret && !ir_r[0] |=>
      $stable(w_r) && $stable(bank_select_register_r))
    else $error("return changed registers");
  flush_seq_a: assert property (
    xfer_end_s |=> dead_cycle_s)
    else $error("no dead cycle after transfer");
endmodule

//--- tb.sv
/*
  Self-checking bench for the negate, stack, call and return slice.
  Assumes the design files and nsc_pkg are compiled first.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic instr_valid = 1'b0;
  logic ext_set_en = 1'b0;
  logic irq_prio_en = 1'b0;
  logic isr_low_level = 1'b0;
  logic shadow_load = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [11:0] fsr2_base = 12'h100;
  logic [7:0] mem_rd_data = 8'h00;
  // Observed outputs
  logic [1:0] q_phase_r;
  logic [20:0] pc_r;
  logic [7:0] w_r, bank_select_register_r, mem_wdata_r;
  logic [4:0] flags_r;
  logic global_irq_enable_high_r, peripheral_irq_enable_low_r;
  logic [11:0] mem_addr_r;
  logic mem_rd_r, mem_wr_r, flush_r, soft_reset_r;
  // Scoreboard
  int bad_count = 0;
  int n_checks = 0;
  int rd_n, wr_n, fl_n, sr_n;
  logic [11:0] addr_s;
  logic [7:0] wd_s;
  logic [20:0] pc_e;
  logic [7:0] w_e;
  logic [4:0] fl_e;
  logic [20:0] stk_e[$];

  // 25 MHz core clock
  always #20 clk = ~clk;

  nsc_exec i_dut (.clk, .sys_rst, .instr_valid, .instr, .ext_set_en,
    .fsr2_base, .irq_prio_en, .isr_low_level, .shadow_load, .mem_rd_data,
    .q_phase_r, .pc_r, .w_r, .flags_r, .bank_select_register_r,
    .global_irq_enable_high_r, .peripheral_irq_enable_low_r, .mem_addr_r,
    .mem_rd_r, .mem_wr_r, .mem_wdata_r, .flush_r, .soft_reset_r);

  // Compare a value
  task automatic cmp_v(input string nm, input logic [20:0] e,
    input logic [20:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Compare a pulse count
  task automatic cmp_n(input string nm, input int e, input int g);
    cmp_v(nm, 21'(e), 21'(g));
  endtask

  // One edge, then inputs move a fixed delay later
  task automatic cyc;
    @(posedge clk);
    #1;
  endtask

  // Offer one word at Q1 and count pulses over its four quarters
  task automatic step(input logic [15:0] w, input logic v,
    input logic [7:0] op, input logic sh);
    int k;
    k = 0;
    while (q_phase_r !== 2'h0 && k < 8)
    begin
      cyc;
      k++;
    end
    cmp_n("q1 alignment", 0, k / 8);
    instr = w;
    instr_valid = v;
    mem_rd_data = op;
    shadow_load = sh;
    rd_n = 0;
    wr_n = 0;
    fl_n = 0;
    sr_n = 0;
    for (int i = 0; i < 4; i++)
    begin
      cyc;
      instr_valid = 1'b0;
      shadow_load = 1'b0;
      // Released read data no longer shows the operand
      if (i == 2)
        mem_rd_data = ~op;
      if (mem_rd_r === 1'b1)
      begin
        rd_n++;
        addr_s = mem_addr_r;
      end
      if (mem_wr_r === 1'b1)
      begin
        wr_n++;
        wd_s = mem_wdata_r;
      end
      fl_n += int'(flush_r === 1'b1);
      sr_n += int'(soft_reset_r === 1'b1);
    end
  endtask

  // Architectural state against the bench model
  task automatic chk_st;
    cmp_v("pc", pc_e, pc_r);
    cmp_v("w", 21'(w_e), 21'(w_r));
    cmp_v("flags", 21'(fl_e), 21'(flags_r));
  endtask

  // Negate one location and check address, data and flags
  task automatic t_neg(input logic a, input logic [7:0] f,
    input logic ext, input logic [7:0] op, input logic [11:0] ea);
    logic [7:0] r;
    r = 8'h00 - op;
    fl_e = {r[7], op == 8'h80, r == 8'h00, op[3:0] == 4'h0, op == 8'h00};
    ext_set_en = ext;
    step({nsc_pkg::NEG_OPC, a, f}, 1'b1, op, 1'b0);
    pc_e = pc_e + 21'h2;
    cmp_n("neg reads", 1, rd_n);
    cmp_n("neg writes", 1, wr_n);
    cmp_v("neg addr", 21'(ea), 21'(addr_s));
    cmp_v("neg data", 21'(r), 21'(wd_s));
    chk_st;
  endtask

  // Slot after a transfer: offered word must be dropped
  task automatic t_dead;
    step({nsc_pkg::NEG_OPC, 1'b1, 8'h44}, 1'b1, 8'h12, 1'b0);
    cmp_n("flush pulse", 1, fl_n);
    cmp_n("dead access", 0, rd_n + wr_n);
    chk_st;
  endtask

  // Relative call followed by its dead slot
  task automatic do_call(input logic [10:0] n);
    stk_e.push_front(pc_e + 21'h2);
    step({nsc_pkg::RELATIVE_CALL_OP_OPC, n}, 1'b1, 8'h00, 1'b0);
    pc_e = pc_e + 21'h2 + {{9{n[10]}}, n, 1'b0};
    chk_st;
    t_dead;
  endtask

  // Any return form followed by its dead slot
  task automatic do_ret(input logic [15:0] w);
    step(w, 1'b1, 8'h00, 1'b0);
    pc_e = stk_e.pop_front();
    chk_st;
    t_dead;
  endtask

  // Plain single-cycle word
  task automatic t_one(input logic [15:0] w, input logic v);
    step(w, v, 8'h00, 1'b0);
    if (v)
      pc_e = pc_e + 21'h2;
    cmp_n("nop access", 0, rd_n + wr_n + fl_n);
    chk_st;
  endtask

  // Negate addressing modes and flag corners
  task automatic t_negate;
    t_neg(1'b1, 8'h3a, 1'b0, 8'h3a, 12'h03a);
    t_neg(1'b0, 8'h80, 1'b0, 8'h80, 12'hf80);
    t_neg(1'b0, 8'h10, 1'b1, 8'h00, 12'h110);
    t_neg(1'b0, 8'h5f, 1'b1, 8'h01, 12'h15f);
    t_neg(1'b0, 8'h60, 1'b1, 8'h7f, 12'hf60);
    t_neg(1'b1, 8'h20, 1'b1, 8'h08, 12'h020);
    t_neg(1'b0, 8'h10, 1'b0, 8'hff, 12'h010);
  endtask

  // Both no-op forms and an empty fetch slot
  task automatic t_nop;
    t_one(nsc_pkg::NOP_CODE, 1'b1);
    t_one({nsc_pkg::NOP_HI, 12'h5a3}, 1'b1);
    t_one(nsc_pkg::NOP_CODE, 1'b0);
  endtask

  // Calls at offset corners, save, discard and literal return
  task automatic t_calls;
    logic [10:0] offs[3] = '{11'h005, 11'h400, 11'h3ff};
    foreach (offs[i])
    begin
      do_call(offs[i]);
      do_ret({nsc_pkg::RETURN_OPC, 1'b0});
    end
    do_call(11'h003);
    stk_e.push_front(pc_e + 21'h2);
    t_one(nsc_pkg::PUSH_CODE, 1'b1);
    do_ret({nsc_pkg::RETURN_OPC, 1'b0});
    do_ret({nsc_pkg::RETURN_OPC, 1'b0});
    do_call(11'h003);
    t_one(nsc_pkg::PUSH_CODE, 1'b1);
    t_one(nsc_pkg::POP_CODE, 1'b1);
    w_e = 8'h5a;
    do_ret({nsc_pkg::LITERAL_RETURN_OP_OPC, 8'h5a});
  endtask

  // Shadow restore on return with the shadow bit set
  task automatic t_shadow;
    logic [7:0] sw;
    logic [4:0] sf;
    step(nsc_pkg::NOP_CODE, 1'b1, 8'h00, 1'b1);
    pc_e = pc_e + 21'h2;
    sw = w_e;
    sf = fl_e;
    do_call(11'h004);
    t_neg(1'b1, 8'h30, 1'b0, 8'h00, 12'h030);
    do_call(11'h004);
    w_e = 8'h33;
    do_ret({nsc_pkg::LITERAL_RETURN_OP_OPC, 8'h33});
    w_e = sw;
    fl_e = sf;
    do_ret({nsc_pkg::RETURN_OPC, 1'b1});
    cmp_v("bank", 21'h0, 21'(bank_select_register_r));
  endtask

  // Interrupt return sets the chosen enable
  task automatic t_interrupt_return_op;
    do_call(11'h002);
    do_ret({nsc_pkg::INTERRUPT_RETURN_OP_OPC, 1'b0});
    cmp_v("high enable", 21'h1, 21'(global_irq_enable_high_r));
    cmp_v("low enable", 21'h0, 21'(peripheral_irq_enable_low_r));
    irq_prio_en = 1'b1;
    isr_low_level = 1'b1;
    do_call(11'h002);
    do_ret({nsc_pkg::INTERRUPT_RETURN_OP_OPC, 1'b0});
    cmp_v("low enable", 21'h1, 21'(peripheral_irq_enable_low_r));
  endtask

  // Software reset returns pc, w, flags and both enables to reset values
  task automatic t_reset;
    step(nsc_pkg::RESET_CODE, 1'b1, 8'h00, 1'b0);
    cmp_n("soft reset", 1, sr_n);
    pc_e = nsc_pkg::PC_RST;
    w_e = nsc_pkg::W_RST;
    fl_e = nsc_pkg::FLAGS_RST;
    chk_st;
    cmp_v("high enable", 21'h0, 21'(global_irq_enable_high_r));
    cmp_v("low enable", 21'h0, 21'(peripheral_irq_enable_low_r));
    t_one(nsc_pkg::NOP_CODE, 1'b1);
  endtask

  // Prints the counts and the verdict, then stops
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    pc_e = nsc_pkg::PC_RST;
    w_e = nsc_pkg::W_RST;
    fl_e = nsc_pkg::FLAGS_RST;
    chk_st;
    t_negate;
    t_nop;
    t_calls;
    t_shadow;
    t_interrupt_return_op;
    t_reset;
    give_verdict;
  end

  // Watchdog well beyond the expected few hundred cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    bad_count++;
    $display("[ERR] run length expected finish seen timeout");
    give_verdict;
  end
endmodule
